// >>> logic/iy_seq_pkg.sv
// Purpose: shared types and constants for the indexed-y bus cycle sequencer
// Assumes: one bus cycle per mclk, 16-bit address, 8-bit data
// Notes:   cycle numbers count from 1, as the bus sees them
package iy_seq_pkg;

	// ----------------------------------------------------------------
	// bus constants
	// ----------------------------------------------------------------
	localparam logic [15:0] ADDR_ONES     = 16'hffff;
	localparam logic [15:0] SP_STEP       = 16'h0001;
	localparam logic [7:0]  EA_NEXT_STEP  = 8'h01;
	localparam logic [7:0]  PAGE_PREFIX   = 8'h18;
	localparam logic [7:0]  OP2_JUMP      = 8'h6e;
	localparam logic [7:0]  OP2_TEST      = 8'h6d;
	localparam logic [7:0]  OP2_CALL      = 8'had;
	localparam logic        RW_READ       = 1'b1;
	localparam logic        RW_WRITE      = 1'b0;
	localparam logic [7:0]  DATA_IDLE     = 8'h00;

	// ----------------------------------------------------------------
	// offsets from the opcode address
	// ----------------------------------------------------------------
	localparam logic [2:0] OFS_PREFIX = 3'h0;
	localparam logic [2:0] OFS_OP2    = 3'h1;
	localparam logic [2:0] OFS_OFFSET = 3'h2;
	localparam logic [2:0] OFS_MASK   = 3'h3;
	localparam logic [2:0] OFS_BRANCH = 3'h4;

	// ----------------------------------------------------------------
	// cycle numbers and lengths
	// ----------------------------------------------------------------
	localparam logic [3:0] CYC_NONE  = 4'h0;
	localparam logic [3:0] CYC_ONE   = 4'h1;
	localparam logic [3:0] CYC_TWO   = 4'h2;
	localparam logic [3:0] CYC_THREE = 4'h3;
	localparam logic [3:0] CYC_FOUR  = 4'h4;
	localparam logic [3:0] CYC_FIVE  = 4'h5;
	localparam logic [3:0] CYC_SIX   = 4'h6;
	localparam logic [3:0] CYC_SEVEN = 4'h7;
	localparam logic [3:0] CYC_EIGHT = 4'h8;

	typedef enum logic [3:0] {
		GRP_JUMP    = 4'h0,
		GRP_ALU8    = 4'h1,
		GRP_RMW     = 4'h2,
		GRP_TEST    = 4'h3,
		GRP_STORE8  = 4'h4,
		GRP_LOAD16  = 4'h5,
		GRP_STORE16 = 4'h6,
		GRP_ARITH16 = 4'h7,
		GRP_CALL    = 4'h8,
		GRP_BITMOD  = 4'h9,
		GRP_BRBIT   = 4'ha
	} group_t;

	typedef enum logic [2:0] {
		SEL_OPC  = 3'h0,
		SEL_ONES = 3'h1,
		SEL_EA   = 3'h2,
		SEL_EA1  = 3'h3,
		SEL_SP   = 3'h4,
		SEL_SPM1 = 3'h5
	} addr_sel_t;

	typedef enum logic [2:0] {
		WSRC_NONE   = 3'h0,
		WSRC_ACC    = 3'h1,
		WSRC_REG_HI = 3'h2,
		WSRC_REG_LO = 3'h3,
		WSRC_RESULT = 3'h4,
		WSRC_RET_LO = 3'h5,
		WSRC_RET_HI = 3'h6
	} wsrc_t;

	typedef struct packed {
		addr_sel_t  sel;
		logic [2:0] opc_ofs;
		logic       rw;
		wsrc_t      wsrc;
	} bus_step_t;

	typedef struct packed {
		group_t      group;
		logic [15:0] opcode_addr;
		logic [15:0] index_y;
		logic [15:0] stack_ptr;
		logic [15:0] reg_data;
		logic [15:0] ret_addr;
	} req_t;

	typedef struct packed {
		logic [7:0] second_op;
		logic [7:0] offset;
		logic [7:0] operand_hi;
		logic [7:0] operand_lo;
		logic [7:0] mask;
		logic [7:0] branch_off;
		logic       opcode_error;
	} cap_t;

	localparam cap_t CAP_CLEAR = '0;

	function automatic logic [3:0] cycles_of(input group_t g);
		case (g)
			GRP_JUMP:                      cycles_of = CYC_FOUR;
			GRP_ALU8, GRP_STORE8:          cycles_of = CYC_FIVE;
			GRP_LOAD16, GRP_STORE16:       cycles_of = CYC_SIX;
			GRP_BITMOD, GRP_BRBIT:         cycles_of = CYC_EIGHT;
			default:                       cycles_of = CYC_SEVEN;
		endcase
	endfunction

endpackage

// >>> logic/addr_offset_adder.sv
// Purpose: 16-bit base plus unsigned 8-bit offset, carry out dropped
// Assumes: offset is unsigned
// Notes:   pure combinational, used for effective address forming
`timescale 1ns/100ps
module addr_offset_adder #(
	parameter int AW = 16,
	parameter int OW = 8
) (
	input  wire logic [AW-1:0] base,
	input  wire logic [OW-1:0] ofs,
	output logic      [AW-1:0] sum
);
	// wrap at the top of the address space
	assign sum = AW'(base + {{(AW-OW){1'b0}}, ofs});
endmodule

// >>> logic/indexed_y_bus_cycle_sequencer.sv
// Purpose: cycle-by-cycle bus sequencer for prefixed indexed-y instructions
// Assumes: memory answers a read in the same cycle; alu result_byte valid
//          in the cycle before a result write
// Notes:   bus outputs are registered; idle bus shows all-ones read
`timescale 1ns/100ps
module indexed_y_bus_cycle_sequencer
	import iy_seq_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        start,
	input  wire req_t        req,
	input  wire logic [7:0]  rdata,
	input  wire logic [7:0]  result_byte,
	output logic             ready,
	output logic [15:0]      bus_addr,
	output logic             bus_rw,
	output logic [7:0]       bus_wdata,
	output logic [3:0]       cycle_num,
	output logic             done,
	output cap_t             cap
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN  = 2'b10
	} state_t;

	state_t      state_reg,  state_next;
	logic [3:0]  cyc_reg,    cyc_next;
	req_t        req_reg,    req_next;
	cap_t        cap_reg,    cap_next;
	logic        done_reg,   done_next;
	logic [15:0] addr_reg,   addr_next;
	logic        rw_reg,     rw_next;
	logic [7:0]  wdata_reg,  wdata_next;
	logic [15:0] ea;
	logic [15:0] ea1;
	logic [15:0] opc_addr;
	bus_step_t   step;

	// ----------------------------------------------------------------
	// address forming
	// ----------------------------------------------------------------
	addr_offset_adder #(.AW(16), .OW(8)) u_ea (
		.base (req_reg.index_y),
		.ofs  (cap_reg.offset),
		.sum  (ea)
	);
	addr_offset_adder #(.AW(16), .OW(8)) u_ea1 (
		.base (ea),
		.ofs  (EA_NEXT_STEP),
		.sum  (ea1)
	);
	addr_offset_adder #(.AW(16), .OW(8)) u_opc (
		.base (req_reg.opcode_addr),
		.ofs  ({5'h00, step.opc_ofs}),
		.sum  (opc_addr)
	);

	// ----------------------------------------------------------------
	// per-cycle bus plan
	// ----------------------------------------------------------------
	function automatic bus_step_t plan(input group_t g, input logic [3:0] c);
		bus_step_t s;
		s = '{sel: SEL_ONES, opc_ofs: OFS_PREFIX, rw: RW_READ, wsrc: WSRC_NONE};
		case (c)
			CYC_TWO:   s = '{SEL_OPC, OFS_OP2, RW_READ, WSRC_NONE};
			CYC_THREE: s = '{SEL_OPC, OFS_OFFSET, RW_READ, WSRC_NONE};
			CYC_FOUR:  s.sel = SEL_ONES;
			CYC_FIVE: begin
				s.sel = SEL_EA;
				if (g == GRP_STORE8) begin
					s.rw   = RW_WRITE;
					s.wsrc = WSRC_ACC;
				end else if (g == GRP_STORE16) begin
					s.rw   = RW_WRITE;
					s.wsrc = WSRC_REG_HI;
				end
			end
			CYC_SIX: begin
				case (g)
					GRP_LOAD16, GRP_ARITH16: s.sel = SEL_EA1;
					GRP_STORE16:             s = '{SEL_EA1, OFS_PREFIX, RW_WRITE, WSRC_REG_LO};
					GRP_CALL:                s = '{SEL_SP, OFS_PREFIX, RW_WRITE, WSRC_RET_LO};
					GRP_BITMOD, GRP_BRBIT:   s = '{SEL_OPC, OFS_MASK, RW_READ, WSRC_NONE};
					default:                 s.sel = SEL_ONES;
				endcase
			end
			CYC_SEVEN: begin
				case (g)
					GRP_RMW:   s = '{SEL_EA, OFS_PREFIX, RW_WRITE, WSRC_RESULT};
					GRP_CALL:  s = '{SEL_SPM1, OFS_PREFIX, RW_WRITE, WSRC_RET_HI};
					GRP_BRBIT: s = '{SEL_OPC, OFS_BRANCH, RW_READ, WSRC_NONE};
					default:   s.sel = SEL_ONES;
				endcase
			end
			CYC_EIGHT: begin
				if (g == GRP_BITMOD)
					s = '{SEL_EA, OFS_PREFIX, RW_WRITE, WSRC_RESULT};
				else
					s.sel = SEL_ONES;
			end
			default: s.sel = SEL_ONES;
		endcase
		return s;
	endfunction
	// kept out of the next-state process so the opcode adder forms no loop through it
	assign step = plan(req_reg.group, 4'(cyc_reg + CYC_ONE));

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		cyc_next   = cyc_reg;
		req_next   = req_reg;
		cap_next   = cap_reg;
		done_next  = 1'b0;
		addr_next  = addr_reg;
		rw_next    = rw_reg;
		wdata_next = wdata_reg;
		case (state_reg)
			ST_IDLE: begin
				addr_next  = ADDR_ONES;
				rw_next    = RW_READ;
				wdata_next = DATA_IDLE;
				if (start) begin
					state_next = ST_RUN;
					req_next   = req;
					cap_next   = CAP_CLEAR;
					cyc_next   = CYC_ONE;
					addr_next  = req.opcode_addr;
				end
			end
			ST_RUN: begin
				case (cyc_reg)
					CYC_ONE: cap_next.opcode_error = (rdata != PAGE_PREFIX);
					CYC_TWO: begin
						cap_next.second_op = rdata;
						if ((req_reg.group == GRP_JUMP && rdata != OP2_JUMP) ||
						    (req_reg.group == GRP_TEST && rdata != OP2_TEST) ||
						    (req_reg.group == GRP_CALL && rdata != OP2_CALL))
							cap_next.opcode_error = 1'b1;
					end
					CYC_THREE: cap_next.offset = rdata;
					CYC_FIVE:  cap_next.operand_hi = rdata;
					CYC_SIX: begin
						if (req_reg.group == GRP_BITMOD || req_reg.group == GRP_BRBIT)
							cap_next.mask = rdata;
						else
							cap_next.operand_lo = rdata;
					end
					CYC_SEVEN: begin
						if (req_reg.group == GRP_BRBIT)
							cap_next.branch_off = rdata;
					end
					default: cap_next = cap_reg;
				endcase
				if (cyc_reg == cycles_of(req_reg.group)) begin
					// last cycle: no further access
					state_next = ST_IDLE;
					cyc_next   = CYC_NONE;
					done_next  = 1'b1;
					addr_next  = ADDR_ONES;
					rw_next    = RW_READ;
					wdata_next = DATA_IDLE;
				end else begin
					cyc_next = 4'(cyc_reg + CYC_ONE);
					case (step.sel)
						SEL_OPC:  addr_next = opc_addr;
						SEL_EA:   addr_next = ea;
						SEL_EA1:  addr_next = ea1;
						SEL_SP:   addr_next = req_reg.stack_ptr;
						SEL_SPM1: addr_next = 16'(req_reg.stack_ptr - SP_STEP);
						default:  addr_next = ADDR_ONES;
					endcase
					rw_next = step.rw;
					case (step.wsrc)
						WSRC_ACC:    wdata_next = req_reg.reg_data[7:0];
						WSRC_REG_HI: wdata_next = req_reg.reg_data[15:8];
						WSRC_REG_LO: wdata_next = req_reg.reg_data[7:0];
						WSRC_RESULT: wdata_next = result_byte;
						WSRC_RET_LO: wdata_next = req_reg.ret_addr[7:0];
						WSRC_RET_HI: wdata_next = req_reg.ret_addr[15:8];
						default:     wdata_next = DATA_IDLE;
					endcase
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			cyc_reg   <= CYC_NONE;
			req_reg   <= '0;
			cap_reg   <= CAP_CLEAR;
			done_reg  <= 1'b0;
			addr_reg  <= ADDR_ONES;
			rw_reg    <= RW_READ;
			wdata_reg <= DATA_IDLE;
		end else begin
			state_reg <= state_next;
			cyc_reg   <= cyc_next;
			req_reg   <= req_next;
			cap_reg   <= cap_next;
			done_reg  <= done_next;
			addr_reg  <= addr_next;
			rw_reg    <= rw_next;
			wdata_reg <= wdata_next;
		end
	end

	assign ready     = (state_reg == ST_IDLE);
	assign bus_addr  = addr_reg;
	assign bus_rw    = rw_reg;
	assign bus_wdata = wdata_reg;
	assign cycle_num = cyc_reg;
	assign done      = done_reg;
	assign cap       = cap_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	logic run;
	group_t grp;
	assign run = (state_reg == ST_RUN);
	assign grp = req_reg.group;

	a_prefix_fetch: assert property (
		ready && start |=> cycle_num == CYC_ONE && bus_addr == $past(req.opcode_addr) &&
			bus_rw ##1 bus_addr == 16'($past(bus_addr) + {13'h0000, OFS_OP2}))
		else $error("prefix or second byte fetch address wrong");
	a_dummy_cycle4: assert property (
		run && cycle_num == CYC_FOUR |-> bus_addr == ADDR_ONES && bus_rw)
		else $error("cycle 4 is not an all-ones read");
	a_jump_length: assert property (
		run && grp == GRP_JUMP && cycle_num == CYC_FOUR |=> ready && done)
		else $error("jump did not end after 4 cycles");
	a_effective_addr: assert property (
		run && cycle_num == CYC_FIVE |-> bus_addr == 16'(req_reg.index_y + {8'h00, cap.offset}))
		else $error("effective address wrong");
	a_rmw_write: assert property (
		run && grp == GRP_RMW && cycle_num == CYC_FIVE |=> bus_addr == ADDR_ONES && bus_rw
			##1 !bus_rw && bus_addr == $past(bus_addr, 2))
		else $error("modify sequence wrong");
	a_test_no_write: assert property (
		run && grp == GRP_TEST |-> bus_rw)
		else $error("test instruction wrote");
	a_store_byte: assert property (
		run && grp == GRP_STORE8 && cycle_num == CYC_FIVE |-> !bus_rw &&
			bus_wdata == req_reg.reg_data[7:0])
		else $error("byte store data or level wrong");
	a_load16_pair: assert property (
		run && grp == GRP_LOAD16 && cycle_num == CYC_SIX |-> bus_rw &&
			bus_addr == 16'($past(bus_addr) + {8'h00, EA_NEXT_STEP}))
		else $error("16-bit load low byte address wrong");
	a_call_stack: assert property (
		run && grp == GRP_CALL && cycle_num == CYC_SIX |-> !bus_rw &&
			bus_addr == req_reg.stack_ptr ##1 !bus_rw &&
			bus_addr == 16'(req_reg.stack_ptr - SP_STEP))
		else $error("return address push wrong");
	a_mask_fetch: assert property (
		run && (grp == GRP_BITMOD || grp == GRP_BRBIT) && cycle_num == CYC_SIX |->
			bus_addr == 16'(req_reg.opcode_addr + {13'h0000, OFS_MASK}) && bus_rw)
		else $error("mask fetch address wrong");

endmodule

// >>> dv/iy_mem_model.sv
// Purpose: memory and peripheral space seen by the sequencer bus
// Assumes: reads answer in the same cycle, writes land at the rising edge
// Notes:   the bench preloads cells by hierarchical access
`timescale 1ns/100ps
module iy_mem_model
	import iy_seq_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic [15:0] bus_addr,
	input  wire logic        bus_rw,
	input  wire logic [7:0]  bus_wdata,
	output logic      [7:0]  rdata
);
	logic [7:0] mem [0:65535];

	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'(i * 37 + (i >> 8));
		end
	end

	// during a write nobody drives read data, so show the inverse, not a stale copy
	assign rdata = (bus_rw == RW_READ) ? mem[bus_addr] : ~mem[bus_addr];

	always @(posedge mclk) begin
		if (bus_rw == RW_WRITE) begin
			mem[bus_addr] <= bus_wdata;
		end
	end
endmodule

// >>> dv/test_indexed_y_bus_cycle_sequencer.sv
// Purpose: self-checking bench for the indexed-y bus cycle sequencer
// Assumes: inputs change at the falling edge, outputs sampled there too
// Notes:   driver queues one note per bus cycle, monitor pops and compares
`timescale 1ns/100ps
module test_indexed_y_bus_cycle_sequencer
	import iy_seq_pkg::*;
();
	typedef struct packed {
		logic [15:0] a;
		logic        rw;
		logic [7:0]  d;
		logic [3:0]  c;
	} step_t;

	logic        mclk;
	logic        rst;
	logic        start;
	req_t        req;
	logic [7:0]  rdata;
	logic [7:0]  result_byte;
	logic        ready;
	logic [15:0] bus_addr;
	logic        bus_rw;
	logic [7:0]  bus_wdata;
	logic [3:0]  cycle_num;
	logic        done;
	cap_t        cap;
	step_t       steps[$];
	cap_t        caps[$];
	cap_t        cares[$];
	cap_t        care_now;
	logic [3:0]  nq[$];
	logic [3:0]  last_cyc;
	logic [31:0] lfsr;
	int          n_errors;
	int          compares;

	indexed_y_bus_cycle_sequencer uut (.mclk(mclk), .rst(rst), .start(start), .req(req),
		.rdata(rdata), .result_byte(result_byte), .ready(ready), .bus_addr(bus_addr),
		.bus_rw(bus_rw), .bus_wdata(bus_wdata), .cycle_num(cycle_num), .done(done), .cap(cap));
	iy_mem_model mem_i (.mclk(mclk), .bus_addr(bus_addr), .bus_rw(bus_rw),
		.bus_wdata(bus_wdata), .rdata(rdata));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] rnd_next(input logic [31:0] x);
		rnd_next = {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
	endfunction

	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		compares++;
		if (exp !== got) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic rd(input logic [15:0] a, input logic [3:0] c);
		steps.push_back({a, RW_READ, DATA_IDLE, c});
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [3:0] c);
		steps.push_back({a, RW_WRITE, d, c});
	endtask

	task automatic end_sim;
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// driver: one instruction, start held two extra cycles to be refused
	// ----------------------------------------------------------------
	task automatic run(input group_t g, input int round);
		logic [15:0] op;
		logic [15:0] ea;
		logic [7:0]  ofs;
		logic [7:0]  sec;
		logic [7:0]  pre;
		logic        spec;
		req_t        r;
		cap_t        ec;
		cap_t        care;
		int          n;
		n = 0;
		while (ready !== 1'b1 && n < 40) begin
			@(negedge mclk);
			n++;
		end
		check("ready wait", 64'h1, 64'(ready));
		lfsr = rnd_next(lfsr);
		op = {2'b01, lfsr[13:0]};
		ofs = (round == 0) ? {1'b1, lfsr[20:14]} : lfsr[21:14];
		pre = (lfsr[24:22] == 3'h0) ? 8'h19 : PAGE_PREFIX;
		spec = g inside {GRP_JUMP, GRP_TEST, GRP_CALL};
		sec = (g == GRP_JUMP) ? OP2_JUMP : (g == GRP_TEST) ? OP2_TEST : OP2_CALL;
		sec = spec ? (sec ^ {7'h0, lfsr[25] & lfsr[26]}) : lfsr[31:24];
		lfsr = rnd_next(lfsr);
		r.group = g;
		r.opcode_addr = op;
		r.index_y = (round == 0) ? 16'hffc0 : {1'b1, lfsr[14:0]};
		r.stack_ptr = {2'b00, lfsr[29:16]};
		lfsr = rnd_next(lfsr);
		r.reg_data = lfsr[15:0];
		r.ret_addr = lfsr[31:16];
		ea = r.index_y + {8'h00, ofs};
		mem_i.mem[op] = pre;
		mem_i.mem[op + 16'h1] = sec;
		mem_i.mem[op + 16'h2] = ofs;
		ec = CAP_CLEAR;
		care = CAP_CLEAR;
		ec.second_op = sec;
		ec.offset = ofs;
		ec.opcode_error = (pre != PAGE_PREFIX) || (spec && (sec != ((g == GRP_JUMP) ? OP2_JUMP :
			(g == GRP_TEST) ? OP2_TEST : OP2_CALL)));
		ec.operand_hi = mem_i.mem[ea];
		ec.operand_lo = mem_i.mem[ea + 16'h1];
		ec.mask = mem_i.mem[op + 16'h3];
		ec.branch_off = mem_i.mem[op + 16'h4];
		care.second_op = 8'hff;
		care.offset = 8'hff;
		care.opcode_error = 1'b1;
		care.operand_hi = {8{!(g inside {GRP_JUMP, GRP_STORE8, GRP_STORE16})}};
		care.operand_lo = {8{g inside {GRP_LOAD16, GRP_ARITH16}}};
		care.mask = {8{g inside {GRP_BITMOD, GRP_BRBIT}}};
		care.branch_off = {8{g == GRP_BRBIT}};
		rd(op, CYC_ONE);
		rd(op + 16'h1, CYC_TWO);
		rd(op + 16'h2, CYC_THREE);
		rd(ADDR_ONES, CYC_FOUR);
		case (g)
			GRP_ALU8: rd(ea, CYC_FIVE);
			GRP_RMW: begin
				rd(ea, CYC_FIVE);
				rd(ADDR_ONES, CYC_SIX);
				wr(ea, ~lfsr[7:0], CYC_SEVEN);
			end
			GRP_TEST: begin
				rd(ea, CYC_FIVE);
				rd(ADDR_ONES, CYC_SIX);
				rd(ADDR_ONES, CYC_SEVEN);
			end
			GRP_STORE8: wr(ea, r.reg_data[7:0], CYC_FIVE);
			GRP_LOAD16: begin
				rd(ea, CYC_FIVE);
				rd(ea + 16'h1, CYC_SIX);
			end
			GRP_STORE16: begin
				wr(ea, r.reg_data[15:8], CYC_FIVE);
				wr(ea + 16'h1, r.reg_data[7:0], CYC_SIX);
			end
			GRP_ARITH16: begin
				rd(ea, CYC_FIVE);
				rd(ea + 16'h1, CYC_SIX);
				rd(ADDR_ONES, CYC_SEVEN);
			end
			GRP_CALL: begin
				rd(ea, CYC_FIVE);
				wr(r.stack_ptr, r.ret_addr[7:0], CYC_SIX);
				wr(r.stack_ptr - SP_STEP, r.ret_addr[15:8], CYC_SEVEN);
			end
			GRP_BITMOD: begin
				rd(ea, CYC_FIVE);
				rd(op + 16'h3, CYC_SIX);
				rd(ADDR_ONES, CYC_SEVEN);
				wr(ea, ~lfsr[7:0], CYC_EIGHT);
			end
			GRP_BRBIT: begin
				rd(ea, CYC_FIVE);
				rd(op + 16'h3, CYC_SIX);
				rd(op + 16'h4, CYC_SEVEN);
				rd(ADDR_ONES, CYC_EIGHT);
			end
			default: ;
		endcase
		nq.push_back(steps[$].c);
		caps.push_back(ec);
		cares.push_back(care);
		req = r;
		// kept apart from the store value so a wrong write source shows up
		result_byte = ~lfsr[7:0];
		start = 1'b1;
		@(negedge mclk);
		req.opcode_addr = ~op;
		repeat (2) @(negedge mclk);
		start = 1'b0;
	endtask

	// ----------------------------------------------------------------
	// monitor
	// ----------------------------------------------------------------
	always @(negedge mclk) begin
		if (!rst && cycle_num !== CYC_NONE) begin
			last_cyc = cycle_num;
			if (steps.size() == 0)
				check("extra bus cycle", 64'h0, {bus_addr, cycle_num});
			else
				check("bus cycle", {steps.pop_front(), 1'b0}, {bus_addr, bus_rw, bus_wdata, cycle_num, ready});
		end else if (!rst) begin
			check("idle bus", {ADDR_ONES, RW_READ, DATA_IDLE, 1'b1}, {bus_addr, bus_rw, bus_wdata, ready});
		end
		if (!rst && done === 1'b1) begin
			if (caps.size() == 0)
				check("spurious done", 64'h0, 64'h1);
			else begin
				check("done timing", nq.pop_front(), last_cyc);
				care_now = cares.pop_front();
				check("captures", caps.pop_front() & care_now, cap & care_now);
			end
		end
	end

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		$display("ERROR watchdog expected done seen timeout");
		end_sim;
	end

	initial begin
		rst = 1'b1;
		start = 1'b0;
		req = '0;
		result_byte = 8'h00;
		lfsr = 32'ha4c4261c;
		n_errors = 0;
		compares = 0;
		last_cyc = 4'h0;
		repeat (20) @(negedge mclk);
		rst = 1'b0;
		check("reset state", {1'b1, CYC_NONE, 1'b0, CAP_CLEAR}, {ready, cycle_num, done, cap});
		for (int k = 0; k < 3; k++) begin
			for (int g = 0; g <= 10; g++) begin
				run(group_t'(g), k);
				if (lfsr[1])
					repeat (12) @(negedge mclk);
			end
		end
		// reset in the middle of an instruction must abandon it with no done pulse
		run(GRP_BITMOD, 3);
		rst = 1'b1;
		steps.delete();
		caps.delete();
		cares.delete();
		nq.delete();
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		check("mid-run reset", {1'b1, CYC_NONE, 1'b0, CAP_CLEAR},
			{ready, cycle_num, done, cap});
		run(GRP_JUMP, 3);
		repeat (12) @(negedge mclk);
		check("queues drained", 64'h0, 64'(steps.size() + caps.size() + nq.size()));
		end_sim;
	end
endmodule
